// *** pkg/mfl_consts.vh ***
`ifndef MFL_CONSTS_VH
`define MFL_CONSTS_VH
`define MFL_MOVE_PAT 6'h08
`define MFL_MOVE_HI 11
`define MFL_MOVE_LO 6
`define MFL_DEST_BIT 5
`define MFL_ADDR_HI 4
`define MFL_ADDR_LO 0
`define MFL_LIT_PAT 4'hC
`define MFL_LIT_HI 11
`define MFL_LIT_LO 8
`define MFL_LIT_DATA_HI 7
`define MFL_LIT_DATA_LO 0
`define MFL_ZERO_VAL 8'h00
`define MFL_W_RST 8'h00
`define MFL_Z_RST 1'h0
`define MFL_ADDR_RST 5'h00
`define MFL_DATA_RST 8'h00
`endif

// *** core/mfl_exec.v ***
`timescale 1ns/1ps
`include "mfl_consts.vh"

// Two-stage executor for move-file and load-literal
module mfl_exec (
  // Clock, reset and enable
  input wire core_clk_in,
  input wire nrst_in,
  input wire clk_en_in,
  // Instruction from fetch
  input wire instr_valid_in,
  input wire [11:0] instr_in,
  // File register read and write
  input wire [7:0] file_rdata_in,
  output reg [4:0] file_addr_out,
  output reg file_we_out,
  output reg [4:0] file_waddr_out,
  output reg [7:0] file_wdata_out,
  // Working register, flag and decode strobes
  output reg [7:0] w_out,
  output reg zero_flag_out,
  output reg move_file_instr_out,
  output reg load_literal_instr_out
);

  // Stage one registers the file field as the read address and
  // holds the move-file slot; stage two takes the file data, which
  // the register file returns one cycle after the address, and
  // commits the working register, zero flag and write-back.
  // A literal commits straight from stage one.
  // Hazard: a literal taken while a move-file commits is dropped,
  // so the core must not issue the two back to back in that way.
  // Clock enable low freezes every register, outputs included.

  // Opcode match for the move-file form
  function move_match;
    input [11:0] word;
    begin
      move_match = (word[`MFL_MOVE_HI:`MFL_MOVE_LO] == `MFL_MOVE_PAT);
    end
  endfunction

  // Opcode match for the load-literal form
  function lit_match;
    input [11:0] word;
    begin
      lit_match = (word[`MFL_LIT_HI:`MFL_LIT_LO] == `MFL_LIT_PAT);
    end
  endfunction

  // True when a data byte is all zero
  function is_zero;
    input [7:0] value;
    begin
      is_zero = (value == `MFL_ZERO_VAL);
    end
  endfunction

  // Fields pulled from the instruction word
  wire [4:0] dec_addr;
  wire dec_dest;
  wire [7:0] dec_lit_val;
  assign dec_addr = instr_in[`MFL_ADDR_HI:`MFL_ADDR_LO];
  assign dec_dest = instr_in[`MFL_DEST_BIT];
  assign dec_lit_val = instr_in[`MFL_LIT_DATA_HI:`MFL_LIT_DATA_LO];

  // Decode qualified by the valid strobe
  reg dec_move;
  reg dec_lit;
  always @* begin
    dec_move = 1'b0;
    dec_lit = 1'b0;
    if (instr_valid_in) begin
      dec_move = move_match(instr_in);
      dec_lit = lit_match(instr_in);
    end
  end

  // Execute-stage holding registers
  reg exec_move_r;
  reg exec_dest_r;
  reg [4:0] exec_addr_r;

  // Move-file slot, set when a move-file is taken
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      exec_move_r <= 1'b0;
    end else if (clk_en_in) begin
      exec_move_r <= dec_move;
    end
  end

  // Destination bit travels with the slot
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      exec_dest_r <= 1'b0;
    end else if (clk_en_in) begin
      exec_dest_r <= dec_dest;
    end
  end

  // File address travels with the slot for write-back
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      exec_addr_r <= `MFL_ADDR_RST;
    end else if (clk_en_in) begin
      exec_addr_r <= dec_addr;
    end
  end

  // File read address, registered from the file field
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      file_addr_out <= `MFL_ADDR_RST;
    end else if (clk_en_in) begin
      file_addr_out <= dec_addr;
    end
  end

  // Zero test of the returned file byte
  wire file_is_zero;
  assign file_is_zero = is_zero(file_rdata_in);

  // Next values for the execute stage
  reg [7:0] w_nxt;
  reg zero_nxt;
  reg we_nxt;
  always @* begin
    w_nxt = w_out;
    zero_nxt = zero_flag_out;
    we_nxt = 1'b0;
    if (exec_move_r) begin
      // Move-file in execute wins over a literal arriving now
      zero_nxt = file_is_zero;
      we_nxt = exec_dest_r;
      if (!exec_dest_r) begin
        w_nxt = file_rdata_in;
      end
    end else if (dec_lit) begin
      w_nxt = dec_lit_val;
    end
  end

  // Write-back strobe, one cycle per committed move-file
  // with the destination bit set
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      file_we_out <= 1'b0;
    end else if (clk_en_in) begin
      file_we_out <= we_nxt;
    end
  end

  // Write-back address, the same file the byte came from
  // so the value lands where it was read
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      file_waddr_out <= `MFL_ADDR_RST;
    end else if (clk_en_in) begin
      file_waddr_out <= exec_addr_r;
    end
  end

  // Write-back data, the unchanged file byte
  // only meaningful while the strobe is high
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      file_wdata_out <= `MFL_DATA_RST;
    end else if (clk_en_in) begin
      file_wdata_out <= file_rdata_in;
    end
  end

  // Working register
  // loaded by a move-file to W or by a literal
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      w_out <= `MFL_W_RST;
    end else if (clk_en_in) begin
      w_out <= w_nxt;
    end
  end

  // Zero flag
  // literals leave it alone, move-file always updates it
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      zero_flag_out <= `MFL_Z_RST;
    end else if (clk_en_in) begin
      zero_flag_out <= zero_nxt;
    end
  end

  // Move-file decode strobe
  // high the cycle after a move-file is taken
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      move_file_instr_out <= 1'b0;
    end else if (clk_en_in) begin
      move_file_instr_out <= dec_move;
    end
  end

  // Load-literal decode strobe
  // high even when a commit collision drops the literal
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      load_literal_instr_out <= 1'b0;
    end else if (clk_en_in) begin
      load_literal_instr_out <= dec_lit;
    end
  end
endmodule

// *** bench/mfl_checker.sv ***
`timescale 1ns/1ps
module mfl_chk (
  input wire core_clk_in,
  input wire nrst_in,
  input wire clk_en_in,
  input wire instr_valid_in,
  input wire [11:0] instr_in,
  input wire [7:0] file_rdata_in,
  input wire file_we_out,
  input wire [4:0] file_waddr_out,
  input wire [7:0] file_wdata_out,
  input wire [7:0] w_out,
  input wire zero_flag_out,
  input wire move_file_instr_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // Requests taken at this edge
  wire move_req;
  wire lit_req;
  assign move_req = clk_en_in && instr_valid_in &&
    (instr_in[11:6] == 6'h08);
  assign lit_req = clk_en_in && instr_valid_in &&
    (instr_in[11:8] == 4'hC) && !move_file_instr_out;

  // Move-file commits at this edge, taken at the previous one
  sequence s_move_exec;
    clk_en_in && $past(clk_en_in) && move_file_instr_out;
  endsequence
  sequence s_dest_w;
    !$past(instr_in[5]);
  endsequence
  sequence s_dest_file;
    $past(instr_in[5]);
  endsequence

  a_mov_dec: assert property (move_req |=> move_file_instr_out)
    else $error("move-file decode strobe missing");
  a_dest_w: assert property (s_move_exec ##0 s_dest_w |=>
    !file_we_out && w_out == $past(file_rdata_in))
    else $error("move-file to W wrong");
  a_dest_file: assert property (s_move_exec ##0 s_dest_file |=>
    file_we_out && file_waddr_out == $past(instr_in[4:0], 2) &&
    file_wdata_out == $past(file_rdata_in) && $stable(w_out))
    else $error("move-file write-back wrong");
  a_zero_mov: assert property (s_move_exec |=>
    zero_flag_out == ($past(file_rdata_in) == 8'h00))
    else $error("zero flag wrong after move-file");
  a_lit_w: assert property (lit_req |=>
    w_out == $past(instr_in[7:0]))
    else $error("literal not loaded");
  a_lit_z: assert property (lit_req |=> $stable(zero_flag_out))
    else $error("literal changed zero flag");
endmodule
bind mfl_exec mfl_chk u_chk(.*);

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg clk_en = 1'b1;
  reg valid = 1'b0;
  reg [11:0] instr = 12'h000;
  reg [7:0] rdata = 8'h00;
  wire [4:0] faddr;
  wire fwe;
  wire [4:0] fwaddr;
  wire [7:0] fwdata;
  wire [7:0] w;
  wire z;
  wire mv_seen;
  wire lit_seen;
  integer n_mismatch = 0;
  integer n_checks = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  mfl_exec uut (
    .core_clk_in(clk),
    .nrst_in(nrst),
    .clk_en_in(clk_en),
    .instr_valid_in(valid),
    .instr_in(instr),
    .file_rdata_in(rdata),
    .file_addr_out(faddr),
    .file_we_out(fwe),
    .file_waddr_out(fwaddr),
    .file_wdata_out(fwdata),
    .w_out(w),
    .zero_flag_out(z),
    .move_file_instr_out(mv_seen),
    .load_literal_instr_out(lit_seen)
  );

  // One clock, then the fixed input delay
  task step;
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // Compare one value, count and report a mismatch
  task check(input [7:0] seen, input [7:0] expected);
    begin
      n_checks = n_checks + 1;
      if (seen !== expected) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen,
          expected);
      end
    end
  endtask

  // Load-literal: W at the next edge, zero flag untouched
  task t_lit(input [7:0] x);
    reg zb;
    begin
      zb = z;
      instr = {4'hC, x};
      valid = 1'b1;
      step;
      valid = 1'b0;
      check(w, x);
      check({7'h00, lit_seen}, 8'h01);
      check({7'h00, z}, {7'h00, zb});
    end
  endtask

  // Move-file: address first, file data one cycle later
  task t_mov(input f, input [4:0] a, input [7:0] x);
    reg [7:0] wb;
    begin
      wb = w;
      instr = {6'h08, f, a};
      valid = 1'b1;
      step;
      valid = 1'b0;
      check({3'h0, faddr}, {3'h0, a});
      check({7'h00, mv_seen}, 8'h01);
      rdata = x;
      step;
      rdata = ~x;
      check({7'h00, z}, {7'h00, x == 8'h00});
      check({7'h00, fwe}, {7'h00, f});
      if (f) begin
        check(fwdata, x);
        check({3'h0, fwaddr}, {3'h0, a});
        check(w, wb);
      end else begin
        check(w, x);
      end
    end
  endtask

  // Literal issued while a move-file commits is dropped
  task t_clash(input [7:0] x);
    begin
      instr = {6'h08, 1'b0, 5'h0A};
      valid = 1'b1;
      step;
      instr = {4'hC, ~x};
      rdata = x;
      step;
      valid = 1'b0;
      check(w, x);
      step;
      check(w, x);
    end
  endtask

  // Enable low freezes; the literal lands once enable returns
  task t_freeze(input [7:0] x);
    reg [7:0] wb;
    begin
      wb = w;
      clk_en = 1'b0;
      instr = {4'hC, x};
      valid = 1'b1;
      step;
      step;
      check(w, wb);
      check({7'h00, lit_seen}, 8'h00);
      clk_en = 1'b1;
      step;
      valid = 1'b0;
      check(w, x);
    end
  endtask

  // Counts, verdict and end of run
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  initial begin
    step;
    step;
    step;
    nrst = 1'b1;
    t_mov(1'b0, 5'h03, 8'h00);
    t_lit(8'h5A);
    t_mov(1'b1, 5'h1F, 8'h7E);
    t_mov(1'b0, 5'h11, 8'hC3);
    t_lit(8'h00);
    t_clash(8'h3C);
    t_freeze(8'hA5);
    results;
  end
endmodule
